// File: verilog/spi_master_slave_fifo.sv
// Serial peripheral controller, master or slave, with byte FIFOs and AXI4-Lite registers
`timescale 1ns/100ps

// Overview of operation
// - Separate four-byte FIFOs hold transmit bytes and received bytes.
// - Active-low select is honoured only in slave operation.
// - Serial clock never exceeds a quarter of the system clock.
// - Port enable bit gates the interface; clearing it wipes the event flags.
// - Sample edge bit picks rising (set) or falling (clear) master sampling.
// - Slave sample and shift edges follow polarity and phase.
// - Threshold field sets completion after one to four bytes.
// - Writing the flush bit empties both FIFOs.
// - Divider field picks system clock over 4,6,8,16,22,64,128,256.
// - Bit order zero shifts least significant bit first.
// - Completion flag set by hardware, cleared by zero write or disable.
// - Byte arriving with receive FIFO full sets receive overrun.
// - Data write with transmit FIFO full sets transmit overrun.
// - Transfer starting with transmit FIFO empty sets underrun.
// - Status shows live full and empty of both FIFOs.
// - Data port read pops receive FIFO, write pushes transmit FIFO.
module spi_master_slave_fifo (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // AXI4-Lite write
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial clock
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  // Master out, slave in
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  // Master in, slave out
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  // Slave select
  input wire logic selectN,
  // Interrupt
  output logic spiIrq
);

  logic [7:0] cfgQ;
  logic [7:0] modeQ;
  logic doneQ, rxOvrQ, txOvrQ, txUdrQ;
  logic portEn, isMaster, msbFirst;
  logic [1:0] threshold;
  logic [2:0] divSel;

  // Bus channel holding registers
  logic awHeldQ, wHeldQ;
  logic [11:0] awAddrQ;
  logic [7:0] wDataQ;
  logic wStrbQ;
  logic bvalidQ, rvalidQ;
  logic [1:0] brespQ, rrespQ;
  logic [7:0] rdataQ;
  logic wrEn, arTake, mapped;

  // FIFOs
  logic [7:0] txMem [spi_pkg::FIFO_DEPTH];
  logic [7:0] rxMem [spi_pkg::FIFO_DEPTH];
  logic [spi_pkg::PTR_W-1:0] txWrQ, txRdQ, rxWrQ, rxRdQ;
  logic [spi_pkg::PTR_W-1:0] txCount, rxCount;
  logic txFull, txEmpty, rxFull, rxEmpty;
  logic flush, txPush, txPop, rxPush, rxPop;

  // Pin conditioning
  logic [2:0] pinRaw, pinUsed, filtEn;
  logic sckUsed, dinUsed, ssnUsed;
  logic sckPrevQ, selPrevQ, selActive;

  // Shift engine
  spi_pkg::masterState_type mStateQ;
  logic [7:0] halfCntQ;
  logic [4:0] edgeCntQ;
  logic sckQ;
  logic [7:0] txShiftQ, rxShiftQ, rxNext, loadByte;
  logic [3:0] bitCntQ;
  logic [1:0] byteCntQ;
  logic sampleRising, halfDone, masterStart, slaveStart;
  logic sckRise, sckFall, sampleEvt, shiftEvt, byteDone, loadEvt;

  function automatic logic [7:0] reverse8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  assign portEn = cfgQ[spi_pkg::CFG_PORT_EN];
  assign isMaster = cfgQ[spi_pkg::CFG_MASTER];
  assign msbFirst = modeQ[spi_pkg::MODE_DIR];
  assign threshold = modeQ[spi_pkg::MODE_THR_HI:spi_pkg::MODE_THR_LO];
  assign divSel = modeQ[spi_pkg::MODE_DIV_HI:spi_pkg::MODE_DIV_LO];

  // ---------------- AXI4-Lite slave ----------------
  assign awready = !awHeldQ && !bvalidQ;
  assign wready = !wHeldQ && !bvalidQ;
  assign arready = !rvalidQ;
  assign bvalid = bvalidQ;
  assign bresp = brespQ;
  assign rvalid = rvalidQ;
  assign rresp = rrespQ;
  assign rdata = {24'h000000, rdataQ};
  assign wrEn = awHeldQ && wHeldQ && wStrbQ;
  assign arTake = arvalid && !rvalidQ;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      awHeldQ <= 1'b0;
      awAddrQ <= '0;
    end
    else if (awvalid && awready)
    begin
      awHeldQ <= 1'b1;
      awAddrQ <= awaddr;
    end
    else if (awHeldQ && wHeldQ)
    begin
      awHeldQ <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wHeldQ <= 1'b0;
      wDataQ <= '0;
      wStrbQ <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      wHeldQ <= 1'b1;
      wDataQ <= wdata[7:0];
      wStrbQ <= wstrb[0];
    end
    else if (awHeldQ && wHeldQ)
    begin
      wHeldQ <= 1'b0;
    end
  end

  always_comb
  begin
    unique case (awAddrQ)
      spi_pkg::ADDR_CONFIG, spi_pkg::ADDR_MODE, spi_pkg::ADDR_STATUS, spi_pkg::ADDR_DATA:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      bvalidQ <= 1'b0;
      brespQ <= spi_pkg::RESP_OKAY;
    end
    else if (awHeldQ && wHeldQ)
    begin
      bvalidQ <= 1'b1;
      brespQ <= mapped ? spi_pkg::RESP_OKAY : spi_pkg::RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalidQ <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rvalidQ <= 1'b0;
      rrespQ <= spi_pkg::RESP_OKAY;
      rdataQ <= '0;
    end
    else if (arTake)
    begin
      rvalidQ <= 1'b1;
      rrespQ <= spi_pkg::RESP_OKAY;
      unique case (araddr)
        spi_pkg::ADDR_CONFIG:
          rdataQ <= cfgQ;
        spi_pkg::ADDR_MODE:
          rdataQ <= modeQ;
        spi_pkg::ADDR_STATUS:
          rdataQ <= {doneQ, rxOvrQ, txOvrQ, txUdrQ, rxFull, rxEmpty, txFull, txEmpty};
        spi_pkg::ADDR_DATA:
          rdataQ <= rxEmpty ? 8'h00 : rxMem[rxRdQ[1:0]];
        default:
        begin
          rdataQ <= 8'h00;
          rrespQ <= spi_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rready)
    begin
      rvalidQ <= 1'b0;
    end
  end

  // ---------------- Registers ----------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      cfgQ <= spi_pkg::CONFIG_RESET;
    else if (wrEn && awAddrQ == spi_pkg::ADDR_CONFIG)
      cfgQ <= wDataQ;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      modeQ <= spi_pkg::MODE_RESET;
    else if (wrEn && awAddrQ == spi_pkg::ADDR_MODE)
      modeQ <= wDataQ & spi_pkg::MODE_STORE_MASK;
  end

  assign flush = wrEn && awAddrQ == spi_pkg::ADDR_MODE && wDataQ[spi_pkg::MODE_FLUSH];

  // Flags: set wins over a zero write; disable clears all
  logic stWr;
  assign stWr = wrEn && awAddrQ == spi_pkg::ADDR_STATUS;

  always_ff @(posedge sys_clk)
  begin
    if (srst || !portEn)
    begin
      doneQ <= 1'b0;
      rxOvrQ <= 1'b0;
      txOvrQ <= 1'b0;
      txUdrQ <= 1'b0;
    end
    else
    begin
      if (byteDone && byteCntQ == threshold)
        doneQ <= 1'b1;
      else if (stWr && !wDataQ[spi_pkg::ST_DONE])
        doneQ <= 1'b0;
      if (byteDone && rxFull)
        rxOvrQ <= 1'b1;
      else if (stWr && !wDataQ[spi_pkg::ST_RX_OVR])
        rxOvrQ <= 1'b0;
      if (wrEn && awAddrQ == spi_pkg::ADDR_DATA && txFull)
        txOvrQ <= 1'b1;
      else if (stWr && !wDataQ[spi_pkg::ST_TX_OVR])
        txOvrQ <= 1'b0;
      if (slaveStart && txEmpty)
        txUdrQ <= 1'b1;
      else if (stWr && !wDataQ[spi_pkg::ST_TX_UDR])
        txUdrQ <= 1'b0;
    end
  end

  assign spiIrq = cfgQ[spi_pkg::CFG_IRQ_EN] && (doneQ || rxOvrQ || txOvrQ || txUdrQ);

  // Bytes completed towards the threshold
  always_ff @(posedge sys_clk)
  begin
    if (srst || !portEn || flush)
      byteCntQ <= 2'h0;
    else if (byteDone)
      byteCntQ <= (byteCntQ == threshold) ? 2'h0 : byteCntQ + 2'h1;
  end

  // ---------------- FIFOs ----------------
  assign txCount = txWrQ - txRdQ;
  assign rxCount = rxWrQ - rxRdQ;
  assign txFull = txCount == spi_pkg::FIFO_FULL_COUNT;
  assign txEmpty = txCount == '0;
  assign rxFull = rxCount == spi_pkg::FIFO_FULL_COUNT;
  assign rxEmpty = rxCount == '0;
  assign txPush = wrEn && awAddrQ == spi_pkg::ADDR_DATA && !txFull;
  assign txPop = loadEvt && !txEmpty;
  assign rxPush = byteDone && !rxFull;
  assign rxPop = arTake && araddr == spi_pkg::ADDR_DATA && !rxEmpty;

  always_ff @(posedge sys_clk)
  begin
    if (srst || flush)
      txWrQ <= '0;
    else if (txPush)
      txWrQ <= txWrQ + 3'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst || flush)
      txRdQ <= '0;
    else if (txPop)
      txRdQ <= txRdQ + 3'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst || flush)
      rxWrQ <= '0;
    else if (rxPush)
      rxWrQ <= rxWrQ + 3'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst || flush)
      rxRdQ <= '0;
    else if (rxPop)
      rxRdQ <= rxRdQ + 3'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (txPush)
      txMem[txWrQ[1:0]] <= wDataQ;
    if (rxPush)
      rxMem[rxWrQ[1:0]] <= rxNext;
  end

  // ---------------- Pin filters ----------------
  assign pinRaw = {selectN, isMaster ? misoIn : mosiIn, sckIn};
  assign filtEn = {cfgQ[spi_pkg::CFG_SELECT_FILT], {2{cfgQ[spi_pkg::CFG_DATA_CLK_FILT]}}};

  genvar g;
  for (g = 0; g < 3; g++)
  begin : gFilter
    logic rawQ, prevQ, filtQ;
    always_ff @(posedge sys_clk)
    begin
      if (srst)
      begin
        rawQ <= spi_pkg::PIN_RESET[g];
        prevQ <= spi_pkg::PIN_RESET[g];
        filtQ <= spi_pkg::PIN_RESET[g];
      end
      else
      begin
        rawQ <= pinRaw[g];
        prevQ <= rawQ;
        if (rawQ == prevQ)
          filtQ <= prevQ;
      end
    end
    assign pinUsed[g] = filtEn[g] ? filtQ : rawQ;
  end

  assign sckUsed = pinUsed[0];
  assign dinUsed = pinUsed[1];
  assign ssnUsed = pinUsed[2];
  assign selActive = portEn && !isMaster && !ssnUsed;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sckPrevQ <= 1'b0;
      selPrevQ <= 1'b0;
    end
    else
    begin
      sckPrevQ <= sckUsed;
      selPrevQ <= selActive;
    end
  end

  // ---------------- Master clock generator ----------------
  assign halfDone = halfCntQ == spi_pkg::HALF_PERIOD[divSel] - 8'h01;
  assign masterStart = mStateQ == spi_pkg::MS_IDLE && portEn && isMaster && !txEmpty;

  always_ff @(posedge sys_clk)
  begin
    if (srst || !portEn || !isMaster)
    begin
      mStateQ <= spi_pkg::MS_IDLE;
      halfCntQ <= '0;
      edgeCntQ <= '0;
      sckQ <= cfgQ[spi_pkg::CFG_CPOL];
    end
    else
    begin
      unique case (mStateQ)
        spi_pkg::MS_IDLE:
        begin
          sckQ <= cfgQ[spi_pkg::CFG_CPOL];
          halfCntQ <= '0;
          edgeCntQ <= '0;
          if (masterStart)
            mStateQ <= spi_pkg::MS_RUN;
        end
        spi_pkg::MS_RUN:
        begin
          halfCntQ <= halfDone ? 8'h00 : halfCntQ + 8'h01;
          if (halfDone)
          begin
            sckQ <= !sckQ;
            edgeCntQ <= edgeCntQ + 5'h01;
            if (edgeCntQ == spi_pkg::EDGES_PER_BYTE - 5'h01)
              mStateQ <= spi_pkg::MS_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------- Edge events ----------------
  // Master: sample edge from config; slave: from polarity and phase
  assign sampleRising = isMaster ? cfgQ[spi_pkg::CFG_SAMPLE_EDGE]
                               : cfgQ[spi_pkg::CFG_CPOL] == cfgQ[spi_pkg::CFG_CPHA];
  always_comb
  begin
    if (isMaster)
    begin
      sckRise = mStateQ == spi_pkg::MS_RUN && halfDone && !sckQ;
      sckFall = mStateQ == spi_pkg::MS_RUN && halfDone && sckQ;
    end
    else
    begin
      sckRise = selActive && sckUsed && !sckPrevQ;
      sckFall = selActive && !sckUsed && sckPrevQ;
    end
  end

  assign sampleEvt = sampleRising ? sckRise : sckFall;
  assign shiftEvt = sampleRising ? sckFall : sckRise;
  assign byteDone = sampleEvt && bitCntQ == spi_pkg::LAST_BIT;
  assign slaveStart = (selActive && !selPrevQ) || (selActive && byteDone);
  assign loadEvt = masterStart || slaveStart;
  assign loadByte = txEmpty ? 8'h00 : txMem[txRdQ[1:0]];
  // Received byte always enters at bit 0; reversed for least-first order
  assign rxNext = msbFirst ? {rxShiftQ[6:0], dinUsed}
                           : reverse8({rxShiftQ[6:0], dinUsed});

  // ---------------- Shift registers ----------------
  always_ff @(posedge sys_clk)
  begin
    if (srst || !portEn)
    begin
      txShiftQ <= '0;
      rxShiftQ <= '0;
      bitCntQ <= '0;
    end
    else if (!isMaster && !selActive)
    begin
      bitCntQ <= '0;
    end
    else
    begin
      if (loadEvt)
        txShiftQ <= msbFirst ? loadByte : reverse8(loadByte);
      else if (shiftEvt && bitCntQ != 4'h0)
        txShiftQ <= {txShiftQ[6:0], 1'b0};
      if (loadEvt)
        bitCntQ <= '0;
      else if (sampleEvt)
      begin
        rxShiftQ <= {rxShiftQ[6:0], dinUsed};
        bitCntQ <= bitCntQ + 4'h1;
      end
    end
  end

  // ---------------- Pins ----------------
  assign sckOut = sckQ;
  assign sckOe = portEn && isMaster;
  assign mosiOut = txShiftQ[7];
  assign mosiOe = portEn && isMaster;
  assign misoOut = txShiftQ[7];
  assign misoOe = selActive;

endmodule // spi_master_slave_fifo

// File: verilog/spi_pkg.sv
// Constants and types shared by the serial peripheral controller
package spi_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONFIG = 8'ha1;
  localparam logic [7:0] IDX_MODE = 8'ha2;
  localparam logic [7:0] IDX_STATUS = 8'ha3;
  localparam logic [7:0] IDX_DATA = 8'ha4;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] ADDR_CONFIG = {2'h0, IDX_CONFIG, 2'h0};
  localparam logic [11:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_DATA = {2'h0, IDX_DATA, 2'h0};

  // spi_configuration fields
  localparam int CFG_IRQ_EN = 7;
  localparam int CFG_PORT_EN = 6;
  localparam int CFG_MASTER = 5;
  localparam int CFG_CPOL = 4;
  localparam int CFG_CPHA = 3;
  localparam int CFG_SAMPLE_EDGE = 2;
  localparam int CFG_DATA_CLK_FILT = 1;
  localparam int CFG_SELECT_FILT = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h20;

  // spi_mode_control fields
  localparam int MODE_THR_HI = 7;
  localparam int MODE_THR_LO = 6;
  localparam int MODE_FLUSH = 5;
  localparam int MODE_DIV_HI = 3;
  localparam int MODE_DIV_LO = 1;
  localparam int MODE_DIR = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_STORE_MASK = 8'hcf;

  // spi_status_flags fields
  localparam int ST_DONE = 7;
  localparam int ST_RX_OVR = 6;
  localparam int ST_TX_OVR = 5;
  localparam int ST_TX_UDR = 4;
  localparam int ST_RX_FULL = 3;
  localparam int ST_RX_EMPTY = 2;
  localparam int ST_TX_FULL = 1;
  localparam int ST_TX_EMPTY = 0;

  // FIFO geometry
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 3;
  localparam logic [2:0] FIFO_FULL_COUNT = 3'h4;

  // Half periods of the master serial clock, in system clocks, per divider code
  localparam logic [7:0] HALF_PERIOD [8] = '{8'h02, 8'h03, 8'h04, 8'h08,
                                             8'h0b, 8'h20, 8'h40, 8'h80};
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

  // Filter pins: sck, data in, select; reset levels
  localparam logic [2:0] PIN_RESET = 3'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {MS_IDLE, MS_RUN} masterState_type;

endpackage

// File: tb/spi_props.sv
// Bus and pin assertions for the serial controller
`timescale 1ns/100ps
module spi_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Serial pins
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic misoOe,
  input wire logic selectN
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rdWaiting;
    rvalid && !rready;
  endsequence
  AST_WR_ANSWER: assert property (wrTaken |-> ##[1:2] bvalid)
    else $error("write response missing");
  AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read response missing");
  AST_RD_HOLD: assert property (rdWaiting |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_WR_HOLD: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  AST_AW_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answering");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("read taken while answering");
  AST_SCK_RATE: assert property (sckOe && $changed(sckOut) |=> $stable(sckOut))
    else $error("serial clock too fast");
  AST_OE_EXCL: assert property (sckOe |-> !misoOe)
    else $error("master drives slave output");
  AST_SEL_GATE: assert property (selectN [*5] |-> !misoOe)
    else $error("slave output without select");
endmodule // spi_props

bind spi_master_slave_fifo spi_props chk (.sys_clk, .srst, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .sckOut,
  .sckOe, .misoOe, .selectN);

// File: tb/spi_partner.sv
// Serial slave model answering master transfers, mode 0
`timescale 1ns/100ps
module spi_partner (
  // Serial lines
  input wire logic sck,
  input wire logic sckOe,
  input wire logic mosi,
  output logic miso,
  // Reply byte and last byte seen
  input wire logic [7:0] reply,
  output logic [7:0] captured
);
  logic [2:0] cnt = 3'h0;
  logic [2:0] outIdx = 3'h0;
  logic [7:0] sh = 8'h00;
  initial captured = 8'h00;
  // Sample on rising edge, first bit taken as most significant
  always @(posedge sck)
  begin
    sh = {sh[6:0], mosi};
    if (cnt == 3'h7)
      captured = sh;
    cnt = cnt + 3'h1;
  end
  // Next bit shifted out on falling edge
  always @(negedge sck)
    outIdx = cnt;
  // Released line shows the inverse of the bit selected by outIdx
  assign miso = sckOe ? reply[~outIdx] : ~reply[~outIdx];
endmodule // spi_partner

// File: tb/tb_top.sv
// Self-checking bench for the serial controller
`timescale 1ns/100ps
module tb_top;
  localparam logic [11:0] CFG = spi_pkg::ADDR_CONFIG;
  localparam logic [11:0] MOD = spi_pkg::ADDR_MODE;
  localparam logic [11:0] STA = spi_pkg::ADDR_STATUS;
  localparam logic [11:0] DAT = spi_pkg::ADDR_DATA;
  localparam int DIV [8] = '{4, 6, 8, 16, 22, 64, 128, 256};
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic sckIn = 1'b0;
  logic mosiIn = 1'b0;
  logic selectN = 1'b1;
  logic [7:0] reply = 8'h3c;
  logic awready, wready, bvalid, arready, rvalid, sckOut, sckOe;
  logic misoIn, misoOut, mosiOut, mosiOe, misoOe, spiIrq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] captured;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;

  spi_master_slave_fifo dut (.sys_clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .sckIn, .sckOut, .sckOe, .mosiIn, .mosiOut, .mosiOe, .misoIn,
    .misoOut, .misoOe, .selectN, .spiIrq);
  spi_partner peer (.sck(sckOut), .sckOe, .mosi(mosiOut), .miso(misoIn), .reply, .captured);

  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(r));
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] r, output logic [31:0] d);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    chk("rresp", 32'(rresp), 32'(r));
  endtask

  task automatic rc(input string n, input logic [11:0] a, input logic [7:0] e);
    logic [31:0] v;
    rd(a, 2'h0, v);
    chk(n, v, {24'h0, e});
  endtask

  // Bench as master on the slave pins: drive edge, then sample edge
  task automatic sx(input logic [7:0] b, input logic pol, output logic [7:0] got);
    int i;
    got = 8'h00;
    @(posedge sys_clk);
    sckIn <= pol;
    repeat (8) @(posedge sys_clk);
    selectN <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("oe", 32'({sckOe, mosiOe, misoOe}), 32'h1);
    for (i = 7; i >= 0; i--)
    begin
      sckIn <= 1'b0;
      mosiIn <= b[i];
      repeat (8) @(posedge sys_clk);
      sckIn <= 1'b1;
      got[i] = misoOut;
      repeat (8) @(posedge sys_clk);
    end
    sckIn <= pol;
    repeat (8) @(posedge sys_clk);
    selectN <= 1'b1;
  endtask

  initial
  begin
    logic [31:0] v;
    int n;
    int h;
    logic [7:0] g;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    rc("config", CFG, 8'h20);
    rc("mode", MOD, 8'h00);
    rc("status", STA, 8'h05);
    rd(12'h000, 2'h2, v);
    chk("unmapped", v, 32'h0);
    wr(12'h000, 8'hff, 2'h2);
    wr(MOD, 8'hff, 2'h0);
    rc("mode", MOD, 8'hcf);
    // Idle slave: writes pile up in the transmit buffer
    wr(CFG, 8'h40, 2'h0);
    for (n = 0; n < 5; n++)
      wr(DAT, 8'(n), 2'h0);
    rc("status", STA, 8'h26);
    wr(STA, 8'h00, 2'h0);
    rc("status", STA, 8'h06);
    wr(MOD, 8'h21, 2'h0);
    rc("status", STA, 8'h05);
    // Master, most significant bit first
    wr(CFG, 8'he4, 2'h0);
    chk("oe", 32'({sckOe, mosiOe, misoOe}), 32'h6);
    wr(DAT, 8'ha5, 2'h0);
    repeat (60) @(posedge sys_clk);
    chk("peer rx", 32'(captured), 32'h0a5);
    rc("status", STA, 8'h81);
    chk("irq", 32'(spiIrq), 32'h1);
    rc("data", DAT, 8'h3c);
    wr(STA, 8'h00, 2'h0);
    @(posedge sys_clk);
    chk("irq", 32'(spiIrq), 32'h0);
    // Least significant bit first
    reply <= 8'h35;
    wr(MOD, 8'h00, 2'h0);
    wr(DAT, 8'h01, 2'h0);
    repeat (60) @(posedge sys_clk);
    chk("peer rx", 32'(captured), 32'h80);
    rc("data", DAT, 8'hac);
    // Four-byte threshold, then receive overrun
    reply <= 8'h3c;
    wr(MOD, 8'he1, 2'h0);
    wr(STA, 8'h00, 2'h0);
    for (n = 0; n < 3; n++)
      wr(DAT, 8'h5a, 2'h0);
    repeat (150) @(posedge sys_clk);
    rc("status", STA, 8'h01);
    wr(DAT, 8'h5a, 2'h0);
    repeat (60) @(posedge sys_clk);
    rc("status", STA, 8'h89);
    wr(DAT, 8'h5a, 2'h0);
    repeat (60) @(posedge sys_clk);
    rc("status", STA, 8'hc9);
    rc("data", DAT, 8'h3c);
    wr(MOD, 8'he1, 2'h0);
    rc("status", STA, 8'hc5);
    wr(CFG, 8'ha4, 2'h0);
    rc("status", STA, 8'h05);
    // Serial clock half period for every divider code
    wr(CFG, 8'he4, 2'h0);
    for (n = 0; n < 8; n++)
    begin
      wr(MOD, {4'h0, 3'(n), 1'b1}, 2'h0);
      wr(DAT, 8'h55, 2'h0);
      while (sckOut !== 1'b1)
        @(posedge sys_clk);
      h = 0;
      while (sckOut === 1'b1)
      begin
        @(posedge sys_clk);
        h++;
      end
      chk("sck half", 32'(h), 32'(DIV[n] / 2));
      repeat (16 * DIV[n]) @(posedge sys_clk);
    end
    // Slave, select and clock driven by the bench, filters on
    wr(CFG, 8'h03, 2'h0);
    wr(CFG, 8'h43, 2'h0);
    wr(MOD, 8'h21, 2'h0);
    wr(DAT, 8'hc3, 2'h0);
    sx(8'h96, 1'b0, g);
    chk("slave tx", 32'(g), 32'hc3);
    rc("status", STA, 8'h91);
    rc("data", DAT, 8'h96);
    wr(CFG, 8'h5b, 2'h0);
    wr(STA, 8'h00, 2'h0);
    wr(DAT, 8'h81, 2'h0);
    sx(8'h7e, 1'b1, g);
    chk("slave tx", 32'(g), 32'h81);
    rc("status", STA, 8'h91);
    rc("data", DAT, 8'h7e);
    end_sim();
  end
endmodule // tb_top
